// [hw/dlr_consts.svh]
// Opcodes, field positions, reset values and layout constants of the load-register decoder.
`ifndef DLR_CONSTS_SVH
`define DLR_CONSTS_SVH
`define DLR_OPC_HI        15
`define DLR_OPC_LO        11
`define DLR_ADR_HI        10
`define DLR_ADR_LO        0
`define DLR_OPC_LOAD_PARAM_REG    5'h00
`define DLR_OPC_LZ        5'h04
`define DLR_OPC_LA        5'h05
`define DLR_OPC_EXEC      5'h10
`define DLR_OPC_LOAD_REPEAT_REG   5'h01
`define DLR_SUB_LEA       11'h533
`define DLR_ACC_W         34
`define DLR_ACC_MSB_FLD   30
`define DLR_ACC_LSB_FLD   15
`define DLR_ACC_RND_BIT   14
`define DLR_EXT_MEM_LSB   1
`define DLR_RND_POS       0
`define DLR_LEN_HI        15
`define DLR_LEN_LO        8
`define DLR_REG_RST       32'h0000_0000
`define DLR_ACC_RST       34'h0_0000_0000
`endif

// [hw/dlr_pkg.sv]
// Types shared by the load-register decoder modules.
package dlr_pkg;
   // Operation picked out of one instruction word.
   typedef enum logic [5:0] {
      DLR_OP_NONE   = 6'b000001,
      DLR_OP_Z      = 6'b000010,
      DLR_OP_ACC    = 6'b000100,
      DLR_OP_EXT    = 6'b001000,
      DLR_OP_PARAM  = 6'b010000,
      DLR_OP_REPEAT = 6'b100000
   } dlr_op_t;
   // Sequencer states of the top module.
   typedef enum logic [2:0] {
      DLR_ST_IDLE = 3'b001,
      DLR_ST_WAIT = 3'b010,
      DLR_ST_DONE = 3'b100
   } dlr_state_t;
endpackage

// [hw/dlr_dec_if.sv]
// Interface carrying an instruction word to the decoder and its decoded result back.
`timescale 1ns/1ps
interface dlr_dec_if;
   import dlr_pkg::*;
   logic [15:0] word;     // Instruction word to decode.
   dlr_op_t     op;       // Decoded operation.
   logic [10:0] addr;     // Address field of the word.
   logic        odd;      // Address field is not double-word aligned.
   modport dec (input word, output op, output addr, output odd);
   modport use_side (output word, input op, input addr, input odd);
endinterface

// [hw/dlr_decode.sv]
// Combinational decoder of the load-register instruction words.
`timescale 1ns/1ps
`include "dlr_consts.svh"
module dlr_decode
   import dlr_pkg::*;
   #(parameter logic [4:0] OPC_REPEAT = `DLR_OPC_LOAD_REPEAT_REG)
(
   dlr_dec_if.dec d
);
   logic [4:0]  opc;   // Major opcode field.
   logic [10:0] fld;   // Low field, address or subcode.

   // Split the word into opcode and operand field.
   assign opc    = d.word[`DLR_OPC_HI:`DLR_OPC_LO];
   assign fld    = d.word[`DLR_ADR_HI:`DLR_ADR_LO];
   assign d.addr = fld;
   // The extended load has no address, so its subcode never counts as odd.
   assign d.odd  = fld[0] & (d.op != DLR_OP_EXT) & (d.op != DLR_OP_NONE);

   // Map opcodes to operations; anything else is left to other decoders.
   always_comb begin
      d.op = DLR_OP_NONE;
      if (opc == `DLR_OPC_LZ) begin
         d.op = DLR_OP_Z;
      end else if (opc == `DLR_OPC_LA) begin
         d.op = DLR_OP_ACC;
      end else if (opc == `DLR_OPC_EXEC && fld == `DLR_SUB_LEA) begin
         d.op = DLR_OP_EXT;
      end else if (opc == `DLR_OPC_LOAD_PARAM_REG) begin
         d.op = DLR_OP_PARAM;
      end else if (opc == OPC_REPEAT) begin
         d.op = DLR_OP_REPEAT;
      end
   end
endmodule

// [hw/dlr_top.sv]
// Load-register instruction sequencer of the vector DSP module.
`timescale 1ns/1ps
`include "dlr_consts.svh"
module dlr_top
   import dlr_pkg::*;
   #(parameter logic [4:0] OPC_REPEAT = `DLR_OPC_LOAD_REPEAT_REG,
     parameter int         WRAP_W     = 4)
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   // Instruction port: one word offered at a time, held until it is accepted.
   input  wire logic              instr_valid,
   input  wire logic [15:0]       instr_word,
   output      logic              instr_ready,
   output      logic              instr_done,
   output      logic              instr_err,
   output      logic              instr_foreign,
   // X vector pointer fields that place element zero of the X vector.
   input  wire logic [15:0]       x_addr,
   input  wire logic [WRAP_W-1:0] x_wrap,
   // Internal memory read port; one double word per request.
   output      logic              mem_rd_req,
   output      logic [15:0]       mem_rd_addr,
   input  wire logic              mem_rd_valid,
   input  wire logic [31:0]       mem_rd_data,
   // Loaded registers and the accumulator, all held in flip-flops.
   output      logic [31:0]       z_ptr,
   output      logic [31:0]       param_reg,
   output      logic [31:0]       repeat_reg,
   output      logic [`DLR_ACC_W-1:0] acc_re,
   output      logic [`DLR_ACC_W-1:0] acc_im,
   output      logic              round_enable_bit,
   output      logic              param_len_zero
);
   dlr_dec_if              dif ();        // Link to the decoder.
   // Sequencer, handshake and pulse registers.
   dlr_state_t             state_ff;      // Sequencer state.
   dlr_op_t                op_ff;         // Operation being carried out.
   logic                   ready_ff;      // Ready for a new instruction.
   logic                   done_ff;       // One-cycle completion pulse.
   logic                   err_ff;        // One-cycle misaligned-address pulse.
   logic                   foreign_ff;    // One-cycle pulse for words not ours.
   logic                   req_ff;        // Memory read request level.
   logic [15:0]            addr_ff;       // Memory word address.
   // Registers loaded from internal memory.
   logic [31:0]            z_ff;          // Z vector pointer register.
   logic [31:0]            param_ff;      // Parameter register.
   logic [31:0]            repeat_ff;     // Repeat register.
   logic [`DLR_ACC_W-1:0]  acc_re_ff;     // Accumulator real part.
   logic [`DLR_ACC_W-1:0]  acc_im_ff;     // Accumulator imaginary part.
   logic                   rnd_ff;        // Registered copy of the rounding bit.
   logic                   lenz_ff;       // Parameter length field reads zero.
   // Combinational helpers that are valid in the current cycle only.
   logic                   take;          // Instruction accepted this cycle.
   logic                   ours;          // Accepted word is one of our loads.
   logic [15:0]            nxt_addr;      // Address for the accepted word.
   logic [`DLR_ACC_W-1:0]  cplx_re;       // Real part built from a complex word.
   logic [`DLR_ACC_W-1:0]  cplx_im;       // Imaginary part built from a complex word.
   logic [`DLR_ACC_W-1:0]  ext_val;       // Accumulator part built from an extended word.

   // Cyclic-buffer address of element n of a vector; n is zero here.
   // The base keeps the pointer bits above the wrap size and the offset wraps
   // inside the buffer, so an element never leaves its buffer whatever the step.
   // The step input stays general so that a later element fetch could reuse
   // the same arithmetic; with a zero step the result equals the pointer.
   function automatic logic [15:0] cyc_addr(input logic [15:0]       base_ptr,
                                            input logic [WRAP_W-1:0] wrap,
                                            input logic [15:0]       step);
      logic [15:0] mask;
      logic [15:0] off;
      mask     = 16'h0000;
      off      = 16'h0000;
      mask     = (16'h0001 << wrap) - 16'h0001;
      off      = (base_ptr + step) & mask;
      cyc_addr = (base_ptr & ~mask) | off;
   endfunction

   // Decoder instance shares opcode layout with this module.
   // The decoder is purely combinational, so the operation seen here belongs
   // to the word on the instruction port in this very cycle. It is trusted
   // only at the edge that accepts the word; op_ff keeps it from then on.
   dlr_decode #(.OPC_REPEAT(OPC_REPEAT)) u_dec (
      .d (dif.dec)
   );

   // Acceptance needs both sides: the offer and our own readiness. A word that
   // is not one of our loads is still accepted, so that the port never stalls
   // on an instruction that another unit is meant to carry out.
   assign dif.word = instr_word;
   assign take     = instr_valid & ready_ff;
   assign ours     = dif.op != DLR_OP_NONE;

   // The extended load fetches X[0]; all others use the word's own address.
   // The address field is eleven bits wide and is zero-extended to the full
   // word address, so these loads reach only the low part of internal memory.
   always_comb begin
      nxt_addr = {5'h00, dif.addr};
      if (dif.op == DLR_OP_EXT) begin
         nxt_addr = cyc_addr(x_addr, x_wrap, 16'h0000);
      end
   end

   // Complex word: low half is real, high half imaginary, sign-extended above.
   // Bits below the rounding bit start at zero so later sums truncate cleanly.
   // The rounding bit comes from the registered copy, which lags the parameter
   // register by one cycle; a parameter load always ends at least two cycles
   // before the next load can fetch, so the lag is never seen by a load.
   always_comb begin
      cplx_re = {{3{mem_rd_data[15]}}, mem_rd_data[15:0], rnd_ff, 14'h0000};
      cplx_im = {{3{mem_rd_data[31]}}, mem_rd_data[31:16], rnd_ff, 14'h0000};
   end

   // Extended word drops its lowest bit and is sign-extended at the top.
   // Bit 31 of the memory value is the sign and is copied into the three
   // guard bits, so the accumulator keeps the sign of the extended value.
   // The dropped bit is not kept: the accumulator part has no place for it.
   always_comb begin
      ext_val = {{3{mem_rd_data[31]}}, mem_rd_data[31:`DLR_EXT_MEM_LSB]};
   end

   // Sequencer: accept, fetch the double word, then report completion.
   // Only one load is in flight at a time; the memory answer may come in the
   // first cycle of the request or any later one, and the sequencer waits for
   // it without a limit, since the memory side owns that latency.
   // The done state lasts a single cycle and gives ready its way back up.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= DLR_ST_IDLE;
      end else begin
         unique case (state_ff)
            DLR_ST_IDLE: begin
               // Misaligned or foreign words never start a fetch.
               if (take && ours && !dif.odd) begin
                  state_ff <= DLR_ST_WAIT;
               end
            end
            DLR_ST_WAIT: begin
               if (mem_rd_valid) begin
                  state_ff <= DLR_ST_DONE;
               end
            end
            DLR_ST_DONE: begin
               state_ff <= DLR_ST_IDLE;
            end
         endcase
      end
   end

   // Latch the operation at acceptance so the instruction port may change.
   // Refused and foreign words are latched as well; this is harmless because
   // op_ff is read only in the wait state, which those words never reach.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         op_ff <= DLR_OP_NONE;
      end else if (take) begin
         op_ff <= dif.op;
      end
   end

   // Ready drops while an instruction is in flight and returns after done.
   // It follows the state rather than a pulse, so it cannot drift from it;
   // a refused or foreign word keeps it high, which lets such words follow
   // each other without a gap.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ready_ff <= 1'b0;
      end else if (state_ff == DLR_ST_IDLE) begin
         ready_ff <= !(take && ours && !dif.odd);
      end else begin
         ready_ff <= state_ff == DLR_ST_DONE;
      end
   end

   // Completion, misalignment and foreign-word pulses.
   // Done lasts exactly one cycle because the wait state ends with the answer;
   // err and foreign stay high as long as such words are taken back to back.
   // At most one of the three is high in any cycle.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         done_ff    <= 1'b0;
         err_ff     <= 1'b0;
         foreign_ff <= 1'b0;
      end else begin
         done_ff    <= state_ff == DLR_ST_WAIT && mem_rd_valid;
         err_ff     <= take && ours && dif.odd;
         foreign_ff <= take && !ours;
      end
   end

   // Memory request is held until the memory answers with data.
   // The address is loaded once at acceptance and is not touched again until
   // the next accepted load, so it stays stable for the whole request.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         req_ff  <= 1'b0;
         addr_ff <= 16'h0000;
      end else if (state_ff == DLR_ST_IDLE && take && ours && !dif.odd) begin
         req_ff  <= 1'b1;
         addr_ff <= nxt_addr;
      end else if (state_ff == DLR_ST_WAIT && mem_rd_valid) begin
         req_ff  <= 1'b0;
      end
   end

   // Pointer, parameter and repeat registers take the fetched double word.
   // The word is stored as it comes; its format is the business of the units
   // that read these registers; only the parameter length field is checked, by the zero-length flag.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         z_ff      <= `DLR_REG_RST;
         param_ff  <= `DLR_REG_RST;
         repeat_ff <= `DLR_REG_RST;
      end else if (state_ff == DLR_ST_WAIT && mem_rd_valid) begin
         if (op_ff == DLR_OP_Z) begin
            z_ff <= mem_rd_data;
         end
         if (op_ff == DLR_OP_PARAM) begin
            param_ff <= mem_rd_data;
         end
         if (op_ff == DLR_OP_REPEAT) begin
            repeat_ff <= mem_rd_data;
         end
      end
   end

   // Accumulator is written only by the two accumulator loads; the pointer,
   // parameter and repeat loads leave both parts exactly as they were.
   // There is no other writer in this block, so keeping the value is a matter
   // of not assigning it rather than of writing the old value back.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         acc_re_ff <= `DLR_ACC_RST;
         acc_im_ff <= `DLR_ACC_RST;
      end else if (state_ff == DLR_ST_WAIT && mem_rd_valid) begin
         if (op_ff == DLR_OP_ACC) begin
            acc_re_ff <= cplx_re;
            acc_im_ff <= cplx_im;
         end else if (op_ff == DLR_OP_EXT) begin
            acc_re_ff <= ext_val;
            acc_im_ff <= ext_val;
         end
      end
   end

   // Rounding bit and zero-length flag track the parameter register.
   // The length check only reports; software must never load a zero length.
   // Both flags are derived every cycle rather than at the load edge, so they
   // are correct from the first edge after reset; reset itself clears the zero-length flag.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rnd_ff  <= 1'b0;
         lenz_ff <= 1'b0;
      end else begin
         rnd_ff  <= param_ff[`DLR_RND_POS];
         lenz_ff <= param_ff[`DLR_LEN_HI:`DLR_LEN_LO] == 8'h00;
      end
   end

   // Every output is a flip-flop.
   // None of the assignments below carries logic, so every output changes
   // only at a clock edge or at the asynchronous reset and cannot glitch between edges.
   assign instr_ready      = ready_ff;
   assign instr_done       = done_ff;
   assign instr_err        = err_ff;
   assign instr_foreign    = foreign_ff;
   assign mem_rd_req       = req_ff;
   assign mem_rd_addr      = addr_ff;
   assign z_ptr            = z_ff;
   assign param_reg        = param_ff;
   assign repeat_reg       = repeat_ff;
   assign acc_re           = acc_re_ff;
   assign acc_im           = acc_im_ff;
   assign round_enable_bit = rnd_ff;
   assign param_len_zero   = lenz_ff;
endmodule

// [bench/dlr_checker.sv]
// Port assertions for the load-register decoder.
`timescale 1ns/1ps
`include "dlr_consts.svh"
module dlr_checker
   import dlr_pkg::*;
   #(parameter logic [4:0] OPC_REPEAT = `DLR_OPC_LOAD_REPEAT_REG)
(
   input wire logic                  mclk,
   input wire logic                  rstn,
   input wire logic                  instr_valid,
   input wire logic [15:0]           instr_word,
   input wire logic                  instr_ready,
   input wire logic                  instr_done,
   input wire logic                  instr_err,
   input wire logic                  instr_foreign,
   input wire logic [15:0]           x_addr,
   input wire logic                  mem_rd_req,
   input wire logic [15:0]           mem_rd_addr,
   input wire logic                  mem_rd_valid,
   input wire logic [31:0]           mem_rd_data,
   input wire logic [31:0]           z_ptr,
   input wire logic [31:0]           param_reg,
   input wire logic [31:0]           repeat_reg,
   input wire logic [`DLR_ACC_W-1:0] acc_re,
   input wire logic [`DLR_ACC_W-1:0] acc_im,
   input wire logic                  round_enable_bit
);
   logic [15:0] word_ff;                                  // Word of the load in flight.
   wire         take = instr_valid && instr_ready;        // Word accepted at this edge.
   wire         fin  = mem_rd_req && mem_rd_valid;        // Memory answers at this edge.
   wire  [4:0]  opc  = word_ff[15:11];                    // Opcode of the load in flight.
   wire  [4:0]  iop  = instr_word[15:11];                 // Opcode being offered.
   wire         ours = iop == 5'h00 || iop == 5'h04 || iop == 5'h05 || iop == OPC_REPEAT;
   // Keeps the accepted word, since results land cycles after the take edge.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         word_ff <= 16'h0000;
      end else if (take) begin
         word_ff <= instr_word;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   z_load_a: assert property (
      fin && opc == 5'h04 |=> instr_done && z_ptr == $past(mem_rd_data))
      else $error("Z pointer load wrong.");
   acc_place_a: assert property (
      fin && opc == 5'h05 |=>
      acc_re[30:14] == {$past(mem_rd_data[15:0]), $past(round_enable_bit)} &&
      acc_im[30:14] == {$past(mem_rd_data[31:16]), $past(round_enable_bit)})
      else $error("Complex accumulator load wrong.");
   ext_both_a: assert property (
      fin && word_ff == 16'h8533 |=>
      acc_re == acc_im && acc_re[30:0] == $past(mem_rd_data[31:1]))
      else $error("Extended load wrong.");
   ext_addr_a: assert property (
      take && instr_word == 16'h8533 |=> mem_rd_req && mem_rd_addr == x_addr)
      else $error("Extended load address wrong.");
   param_load_a: assert property (
      fin && opc == 5'h00 |=> param_reg == $past(mem_rd_data))
      else $error("Parameter load wrong.");
   repeat_load_a: assert property (
      fin && opc == OPC_REPEAT |=> repeat_reg == $past(mem_rd_data))
      else $error("Repeat load wrong.");
   keep_acc_a: assert property (
      fin && (opc == 5'h00 || opc == 5'h04) |=> $stable(acc_re) && $stable(acc_im))
      else $error("Accumulator disturbed.");
   odd_refuse_a: assert property (
      take && ours && instr_word[0] |=> instr_err && !mem_rd_req && instr_ready)
      else $error("Odd address not refused.");
   rd_addr_a: assert property (
      take && ours && !instr_word[0] |=> mem_rd_req && mem_rd_addr == {5'h00, word_ff[10:0]})
      else $error("Read address wrong.");
   foreign_word_a: assert property (
      take && iop == 5'h1f |=> instr_foreign && instr_ready)
      else $error("Foreign word not ignored.");
endmodule
bind dlr_top dlr_checker #(.OPC_REPEAT(OPC_REPEAT)) chk (.mclk, .rstn, .instr_valid, .instr_word,
   .instr_ready, .instr_done, .instr_err, .instr_foreign, .x_addr, .mem_rd_req, .mem_rd_addr,
   .mem_rd_valid, .mem_rd_data, .z_ptr, .param_reg, .repeat_reg, .acc_re, .acc_im, .round_enable_bit);

// [bench/tb.sv]
// Self-checking testbench of the load-register decoder.
`timescale 1ns/1ps
module tb;
   logic        mclk = 1'b0, rstn = 1'b0, instr_valid = 1'b0, mem_rd_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000, x_addr = 16'h0036, mem_rd_addr;
   logic [3:0]  x_wrap = 4'h3;                             // Held so the cyclic address is x_addr.
   logic [31:0] mem_rd_data = 32'h0000_0000, z_ptr, param_reg, repeat_reg;
   logic [33:0] acc_re, acc_im, keep;
   logic        instr_ready, instr_done, instr_err, instr_foreign, mem_rd_req, round_enable_bit;
   logic        param_len_zero;
   int          failures = 0, n_checks = 0, lat = 0, cnt = 0;
   dlr_top uut (.mclk, .rstn, .instr_valid, .instr_word, .instr_ready, .instr_done, .instr_err,
      .instr_foreign, .x_addr, .x_wrap, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
      .z_ptr, .param_reg, .repeat_reg, .acc_re, .acc_im, .round_enable_bit, .param_len_zero);
   initial forever #20 mclk = ~mclk;
   // Memory content; the low word of an even address decides the rounding bit.
   function automatic logic [31:0] memv(input logic [15:0] a);
      return {~a, a ^ 16'h4a5a ^ {15'h0000, a[1]}};
   endfunction
   // Memory answers lat+1 cycles after the request rises; data is scrambled outside the valid cycle.
   always @(posedge mclk) begin
      if (mem_rd_valid) begin
         mem_rd_valid <= 1'b0;
         mem_rd_data  <= ~mem_rd_data;
         cnt          <= 0;
      end else if (mem_rd_req === 1'b1) begin
         if (cnt == lat) begin
            mem_rd_valid <= 1'b1;
            mem_rd_data  <= memv(mem_rd_addr);
         end else cnt <= cnt + 1;
      end
   end
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Offers one word, waits for its outcome pulse and compares done, err and foreign.
   // Either wait running out counts a mismatch and ends the run at once.
   task automatic run(input logic [15:0] w, input logic [2:0] ef);
      int i;
      for (i = 0; i < 50 && instr_ready !== 1'b1; i++) @(posedge mclk);
      if (instr_ready !== 1'b1) begin
         failures++;
         final_report();
      end else begin
         instr_valid <= 1'b1;
         instr_word  <= w;
         @(posedge mclk);
         instr_valid <= 1'b0;
         for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if ((instr_done | instr_err | instr_foreign) === 1'b1) break;
         end
         if (i == 50) begin
            failures++;
            final_report();
         end else begin
            chk(34'({instr_done, instr_err, instr_foreign}), 34'(ef));
         end
      end
   endtask
   // Parameter load then complex load, with the rounding bit taken from the parameter.
   task automatic t_acc(input logic [10:0] pa, input logic [10:0] aa);
      logic [31:0] d;
      logic [31:0] p;
      keep = acc_re;
      d = memv({5'h00, aa});
      p = memv({5'h00, pa});
      run({5'h00, pa}, 3'b100);
      chk(34'(param_reg), 34'(p));
      chk(acc_re, keep);
      // The two derived flags lag the parameter register by one cycle.
      @(posedge mclk);
      chk(34'(round_enable_bit), 34'(p[0]));
      chk(34'(param_len_zero), 34'h0);
      run({5'h05, aa}, 3'b100);
      chk(acc_re, {{3{d[15]}}, d[15:0], p[0], 14'h0000});
      chk(acc_im, {{3{d[31]}}, d[31:16], p[0], 14'h0000});
   endtask
   // Pointer and repeat loads; only the pointer load is checked to leave acc_im as it was.
   task automatic t_regs();
      keep = acc_im;
      run(16'h2010, 3'b100);
      chk(34'(z_ptr), 34'(memv(16'h0010)));
      chk(acc_im, keep);
      run(16'h0812, 3'b100);
      chk(34'(repeat_reg), 34'(memv(16'h0012)));
   endtask
   // Extended load from element zero of X into both parts.
   task automatic t_ext();
      logic [31:0] d;
      d = memv(x_addr);
      run(16'h8533, 3'b100);
      chk(acc_re, {{3{d[31]}}, d[31:1]});
      chk(acc_im, {{3{d[31]}}, d[31:1]});
   endtask
   // Odd address refused and a foreign word ignored, taken two cycles apart.
   task automatic t_refuse();
      keep = 34'(z_ptr);
      run(16'h2011, 3'b010);
      run(16'hf800, 3'b001);
      chk(34'(z_ptr), keep);
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      @(posedge mclk);
      chk(34'({instr_ready, instr_done, instr_err, instr_foreign}), 34'h8);
      chk(34'(param_len_zero), 34'h1);
      t_acc(11'h002, 11'h008);
      lat = 3;
      t_acc(11'h004, 11'h006);
      t_regs();
      lat = 0;
      t_ext();
      t_refuse();
      final_report();
   end
endmodule
